// ---- pkg/sleep_pkg.sv ----
// Purpose: shared constants and types for the sleep-mode clock gating block
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes: register offsets are byte addresses
package sleep_pkg;
   localparam logic [3:0] OFS_SLEEP_CTRL = 4'h0;
   localparam logic [3:0] OFS_MCU_CTRL = 4'h4;
   localparam logic [3:0] OFS_INBUF_DIS0 = 4'h8;
   localparam logic [3:0] OFS_INBUF_DIS1 = 4'hC;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam int SLEEP_EN_POS = 0;
   localparam int SM_LSB = 1;
   localparam int SCAN_DIS_POS = 7;
   localparam logic [2:0] SM_IDLE = 3'h0;
   localparam logic [2:0] SM_ADCNR = 3'h1;
   localparam logic [2:0] SM_PDOWN = 3'h2;
   localparam logic [2:0] SM_PSAVE = 3'h3;
   localparam logic [2:0] SM_STBY = 3'h6;
   localparam logic [3:0] WAKE_HOLD_CYC = 4'h4;
   localparam int STBY_WAKE_CYC = 6;
   localparam logic [3:0] STBY_WAKE_CNT = 4'(STBY_WAKE_CYC - 2);
   localparam logic [7:0] INBUF_DIS_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE = 2'b11
   } sleep_state_e;

   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic asy;
      logic main_osc;
      logic timer_osc;
   } clk_en_s;

   typedef struct packed {
      logic twi_match;
      logic t2_ovf;
      logic t2_cmp;
      logic spm_rdy;
      logic adc_done;
      logic other_io;
      logic [3:0] ext_edge_lo;
      logic [3:0] ext_level_hi;
      logic [3:0] ext_edge_hi;
   } wake_src_s;
endpackage

// ---- src/sleep_ctrl.sv ----
// Purpose: sleep-mode controller gating clock domains and choosing wake sources
// Assumes: one clock, synchronous reset, Avalon-MM slave with waitrequest
// Notes: wake inputs are synchronised; clock enables drive external gates
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl
   import sleep_pkg::*;
#(
   parameter int PINS = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // cpu side
   input wire logic sleep_instr,
   input wire logic global_irq_en,
   input wire logic timer2_async_select,
   input wire logic [1:0] timer2_irq_mask_reg,
   input wire logic crystal_clock_sel,
   // fuses and analog enables
   input wire logic [2:0] brownout_level_fuses,
   input wire logic debug_enable_fuse,
   input wire logic scan_port_enable_fuse,
   input wire logic adc_enable,
   input wire logic comp_enable,
   input wire logic comp_uses_ref,
   input wire logic watchdog_enable,
   // wake sources, asynchronous
   input wire wake_src_s wake_in,
   input wire logic wake_irq_en,
   input wire logic tap_shifting,
   input wire logic tdo_data,
   // clock enables and analog controls
   output clk_en_s clk_en,
   output logic cpu_hold,
   output logic adc_on,
   output logic adc_extended_next,
   output logic comp_on,
   output logic bod_on,
   output logic vref_on,
   output logic watchdog_on,
   output logic [PINS-1:0] input_buf_en0,
   output logic [PINS-1:0] input_buf_en1,
   output logic wake_buf_force,
   output logic scan_port_on,
   output logic tdo_out,
   output logic tdo_oe
);
   localparam int WW = $bits(wake_src_s);

   logic [2:0] sm_q;
   logic sleep_en_q;
   logic scan_dis_q;
   logic [PINS-1:0] inbuf_dis0_q;
   logic [PINS-1:0] inbuf_dis1_q;
   logic avs_waitrequest_q;
   logic [2:0] mode_q;
   sleep_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [WW-1:0] wsync1_q, wsync2_q;
   logic adc_en_prev_q, adc_ext_q;
   logic [31:0] rdata_q;
   clk_en_s clk_en_q;
   logic hold_q, adc_on_q, comp_on_q, bod_q, vref_q, wdt_q, buf_force_q;
   logic [PINS-1:0] buf0_q, buf1_q;
   logic scan_q, tdo_q, tdo_oe_q;

   function automatic logic mode_legal(input logic [2:0] m, input logic xtal);
      return (m == SM_IDLE) || (m == SM_ADCNR) || (m == SM_PDOWN) ||
             (m == SM_PSAVE) || ((m == SM_STBY) && xtal);
   endfunction

   // bus decode
   wire bus_req = avs_read || avs_write;
   // writes land only at the edge where the master sees waitrequest low
   wire bus_accept = bus_req && !avs_waitrequest_q;
   wire wr_ctrl = avs_write && (avs_address == OFS_SLEEP_CTRL);
   wire wr_mcu = avs_write && (avs_address == OFS_MCU_CTRL);
   wire wr_d0 = avs_write && (avs_address == OFS_INBUF_DIS0);
   wire wr_d1 = avs_write && (avs_address == OFS_INBUF_DIS1);
   wire [31:0] rd_mux =
      (avs_address == OFS_SLEEP_CTRL) ?
         {24'h0, st_q != ST_RUN, 3'h0, sm_q, sleep_en_q} :
      (avs_address == OFS_MCU_CTRL) ? {24'h0, scan_dis_q, 7'h0} :
      (avs_address == OFS_INBUF_DIS0) ? 32'(inbuf_dis0_q) :
      (avs_address == OFS_INBUF_DIS1) ? 32'(inbuf_dis1_q) : 32'h0;

   // synchronised wake sources
   wake_src_s ws;
   assign ws = wake_src_s'(wsync2_q);

   wire sleeping = (st_q == ST_SLEEP);
   wire m_idle = mode_q == SM_IDLE;
   wire m_adcnr = mode_q == SM_ADCNR;
   wire m_psave = mode_q == SM_PSAVE;
   wire m_stby = mode_q == SM_STBY;
   wire go_sleep = sleep_instr && sleep_en_q && mode_legal(sm_q, crystal_clock_sel);
   wire t2_irq = (ws.t2_ovf && timer2_irq_mask_reg[0]) ||
                 (ws.t2_cmp && timer2_irq_mask_reg[1]);
   wire t2_wake = t2_irq && global_irq_en && timer2_async_select;
   wire ext_deep = (|ws.ext_edge_lo) || (|ws.ext_level_hi);
   wire ext_any = ext_deep || (|ws.ext_edge_hi);
   // per-mode wake masks
   wire wake_idle = ext_any || ws.t2_ovf || ws.t2_cmp || ws.spm_rdy ||
                    ws.adc_done || ws.other_io;
   wire wake_adcnr = ext_deep || t2_wake || ws.spm_rdy || ws.adc_done;
   wire wake_deep = !m_idle && !m_adcnr && ext_deep;
   wire wake_psave = m_psave && t2_wake;
   wire wake_req = ws.twi_match ||
      (m_idle && wake_idle) ||
      (m_adcnr && wake_adcnr) ||
      wake_deep ||
      wake_psave;
   wire wake_ok = wake_req && wake_irq_en;

   // sleep sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         ST_RUN: begin
            if (go_sleep) begin
               st_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_ok) begin
               st_d = ST_WAKE;
               // standby loads a wake count one higher than the other modes
               cnt_d = m_stby ? STBY_WAKE_CNT : WAKE_HOLD_CYC - 4'h1;
            end
         end
         ST_WAKE: begin
            if (cnt_q == 4'h0) begin
               st_d = ST_RUN;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: st_d = ST_RUN;
      endcase
   end

   // domain enables per mode
   clk_en_s ce;
   wire asy_sel = timer2_async_select;
   wire scan_port_on_w = scan_port_enable_fuse && !scan_dis_q;
   wire dbg_keep = debug_enable_fuse && scan_port_on_w;
   always_comb begin
      ce = '1;
      if (sleeping) begin
         ce.cpu = 1'b0;
         ce.flash = 1'b0;
         ce.io = m_idle;
         ce.adc = m_idle || m_adcnr;
         ce.asy = m_idle || m_adcnr || (m_psave && asy_sel);
         ce.main_osc = m_idle || m_adcnr || m_stby || dbg_keep;
         ce.timer_osc = (m_idle || m_adcnr || m_psave) && asy_sel;
      end else begin
         ce.timer_osc = asy_sel;
      end
   end

   wire [PINS-1:0] dis0 = inbuf_dis0_q;
   wire [PINS-1:0] dis1 = inbuf_dis1_q;
   wire bufs_off = !ce.io && !ce.adc;
   wire comp_w = comp_enable && (!sleeping || m_idle || m_adcnr);
   wire bod_w = brownout_level_fuses != 3'h7;
   wire vref_w = bod_w || comp_w || (comp_enable && comp_uses_ref) || adc_enable;

   // one wait state: low for the cycle after a request is first seen
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest_q <= 1'b1;
      end else begin
         avs_waitrequest_q <= !(bus_req && avs_waitrequest_q);
      end
   end

   // latched on the wait cycle so it stands at the accepting edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0;
      end else if (avs_read && avs_waitrequest_q) begin
         rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sleep_en_q <= 1'b0;
         sm_q <= SM_IDLE;
      end else if (wr_ctrl && bus_accept) begin
         sleep_en_q <= avs_writedata[SLEEP_EN_POS];
         sm_q <= avs_writedata[SM_LSB +: 3];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scan_dis_q <= 1'b0;
      end else if (wr_mcu && bus_accept) begin
         scan_dis_q <= avs_writedata[SCAN_DIS_POS];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inbuf_dis0_q <= INBUF_DIS_RST[PINS-1:0];
      end else if (wr_d0 && bus_accept) begin
         inbuf_dis0_q <= avs_writedata[PINS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inbuf_dis1_q <= INBUF_DIS_RST[PINS-1:0];
      end else if (wr_d1 && bus_accept) begin
         inbuf_dis1_q <= avs_writedata[PINS-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_RUN;
         cnt_q <= 4'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // mode frozen at entry so a later register write cannot alter sleep
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q <= SM_IDLE;
      end else if (st_q == ST_RUN && go_sleep) begin
         mode_q <= sm_q;
      end
   end

   // wake lines come from stopped domains, so two flops before use
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wsync1_q <= '0;
         wsync2_q <= '0;
      end else begin
         wsync1_q <= wake_in;
         wsync2_q <= wsync1_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         adc_en_prev_q <= 1'b0;
         adc_ext_q <= 1'b1;
      end else begin
         adc_en_prev_q <= adc_enable;
         // off-to-on edge arms an extended conversion
         if (adc_enable && !adc_en_prev_q) begin
            adc_ext_q <= 1'b1;
         end else if (ws.adc_done) begin
            adc_ext_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_en_q <= '0;
         hold_q <= 1'b1;
      end else begin
         clk_en_q <= ce;
         hold_q <= (st_d != ST_RUN);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         adc_on_q <= 1'b0;
         comp_on_q <= 1'b0;
         bod_q <= 1'b0;
         vref_q <= 1'b0;
         wdt_q <= 1'b0;
      end else begin
         adc_on_q <= adc_enable;
         comp_on_q <= comp_w;
         bod_q <= bod_w;
         vref_q <= vref_w;
         wdt_q <= watchdog_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         buf0_q <= '0;
         buf1_q <= '0;
         buf_force_q <= 1'b0;
      end else begin
         buf0_q <= bufs_off ? '0 : ~dis0;
         buf1_q <= bufs_off ? '0 : ~dis1;
         buf_force_q <= bufs_off; // wake-pin buffers stay on
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scan_q <= 1'b0;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         scan_q <= scan_port_on_w;
         tdo_q <= tdo_data;
         tdo_oe_q <= scan_port_on_w && tap_shifting;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = avs_waitrequest_q;
   assign clk_en = clk_en_q;
   assign cpu_hold = hold_q;
   assign adc_on = adc_on_q;
   assign adc_extended_next = adc_ext_q;
   assign comp_on = comp_on_q;
   assign bod_on = bod_q;
   assign vref_on = vref_q;
   assign watchdog_on = wdt_q;
   assign input_buf_en0 = buf0_q;
   assign input_buf_en1 = buf1_q;
   assign wake_buf_force = buf_force_q;
   assign scan_port_on = scan_q;
   assign tdo_out = tdo_q;
   assign tdo_oe = tdo_oe_q;
endmodule // sleep_ctrl
`default_nettype wire

// ---- verif/sleep_ctrl_asserts.sv ----
// Purpose: port-level checks for sleep_ctrl
// Assumes: single clock, synchronous reset
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_asserts
   import sleep_pkg::*;
(
   // clock, reset and bus
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic avs_waitrequest,
   // controls and fuses
   input wire logic [2:0] brownout_level_fuses,
   input wire logic scan_port_enable_fuse,
   input wire logic adc_enable,
   input wire logic comp_enable,
   input wire logic watchdog_enable,
   input wire logic tap_shifting,
   // watched outputs
   input wire clk_en_s clk_en,
   input wire logic cpu_hold,
   input wire logic bod_on,
   input wire logic vref_on,
   input wire logic watchdog_on,
   input wire logic scan_port_on,
   input wire logic tdo_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_cpu_stop_held: assert property ($fell(clk_en.cpu) |-> cpu_hold)
      else $error("cpu clock stopped while not held");
   a_flash_with_cpu: assert property ($fell(clk_en.cpu) |-> $fell(clk_en.flash))
      else $error("flash clock not stopped with cpu");
   a_scan_fuse_off: assert property ((!scan_port_enable_fuse)[*2] |-> !scan_port_on)
      else $error("scan port on with fuse clear");
   a_tdo_float: assert property ((!tap_shifting)[*2] |-> !tdo_oe)
      else $error("tdo driven while not shifting");
   a_bod_kept: assert property ((brownout_level_fuses != 3'h7)[*2] |-> bod_on)
      else $error("brownout detector off");
   a_wdog_kept: assert property (watchdog_enable[*2] |-> watchdog_on)
      else $error("watchdog stopped");
   a_vref_idle: assert property
      ((!adc_enable && !comp_enable && brownout_level_fuses == 3'h7)[*2] |-> !vref_on)
      else $error("reference on with no user");
endmodule // sleep_ctrl_asserts
bind sleep_ctrl sleep_ctrl_asserts u_sleep_ctrl_asserts (
   .clk(clk),
   .sys_rst(sys_rst),
   .avs_waitrequest(avs_waitrequest),
   .brownout_level_fuses(brownout_level_fuses),
   .scan_port_enable_fuse(scan_port_enable_fuse),
   .adc_enable(adc_enable),
   .comp_enable(comp_enable),
   .watchdog_enable(watchdog_enable),
   .tap_shifting(tap_shifting),
   .clk_en(clk_en),
   .cpu_hold(cpu_hold),
   .bod_on(bod_on),
   .vref_on(vref_on),
   .watchdog_on(watchdog_on),
   .scan_port_on(scan_port_on),
   .tdo_oe(tdo_oe)
);
`default_nettype wire

// ---- verif/test_sleep_ctrl.sv ----
// Purpose: directed bench for sleep_ctrl
// Assumes: 20 MHz clock, timer2 async select high by default
// Notes: reads sample waitrequest at the edge
`timescale 1ns/1ps
`default_nettype none
module test_sleep_ctrl import sleep_pkg::*; ;
   logic clk, sys_rst, avs_read, avs_write, sleep_instr, global_irq_en;
   logic timer2_async_select, crystal_clock_sel, debug_enable_fuse;
   logic scan_port_enable_fuse, adc_enable, comp_enable, comp_uses_ref;
   logic watchdog_enable, wake_irq_en, tap_shifting, tdo_data;
   logic avs_waitrequest, cpu_hold, adc_on, adc_extended_next, comp_on, bod_on;
   logic vref_on, watchdog_on, wake_buf_force, scan_port_on, tdo_out, tdo_oe;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [1:0] timer2_irq_mask_reg;
   logic [2:0] brownout_level_fuses;
   logic [7:0] input_buf_en0, input_buf_en1;
   wake_src_s wake_in;
   clk_en_s clk_en;
   int err_count = 0;
   int compares = 0;
   localparam wake_src_s w_twi = '{twi_match: 1'b1, default: '0};
   localparam wake_src_s w_io = '{other_io: 1'b1, default: '0};
   localparam wake_src_s w_hi = '{ext_edge_hi: 4'h1, default: '0};
   localparam wake_src_s w_lo = '{ext_edge_lo: 4'h1, default: '0};
   localparam wake_src_s w_ovf = '{t2_ovf: 1'b1, default: '0};

   sleep_ctrl u_sleep_ctrl (.*);

   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      {avs_write, avs_read} <= {wr, !wr};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) err_count++;
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      @(posedge clk);
   endtask

   task automatic nap(input logic [2:0] m);
      bus(1, OFS_SLEEP_CTRL, {28'h0, m, 1'b1});
      sleep_instr <= 1;
      @(posedge clk);
      sleep_instr <= 0;
      repeat (3) @(posedge clk);
   endtask

   task automatic rouse(input wake_src_s w, output int n);
      n = 0;
      wake_in <= w;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_hold !== 1'b0 && n < 30);
      wake_in <= '0;
      repeat (3) @(posedge clk);
   endtask

   task automatic t_regs;
      bus(1, OFS_SLEEP_CTRL, 32'h4);
      bus(0, OFS_SLEEP_CTRL, 0);
      chk(rd, 32'h4);
      bus(1, OFS_INBUF_DIS0, 32'hA5);
      bus(0, OFS_INBUF_DIS0, 0);
      chk(rd, 32'hA5);
      chk(32'(input_buf_en0), 32'h5A);
      chk(32'(input_buf_en1), 32'hFF);
      sleep_instr <= 1;
      @(posedge clk);
      sleep_instr <= 0;
      repeat (3) @(posedge clk);
      chk(32'(cpu_hold), 0);
      bus(1, 4'h2, 32'hFF);
      bus(0, 4'h2, 0);
      chk(rd, 0);
   endtask

   task automatic t_modes;
      logic [2:0] m [5] = '{SM_IDLE, SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY};
      logic [6:0] e [5] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02};
      int n;
      for (int i = 0; i < 5; i++) begin
         nap(m[i]);
         chk(32'(clk_en), 32'(e[i]));
         bus(0, OFS_SLEEP_CTRL, 0);
         chk(rd, {24'h0, 4'h8, m[i], 1'b1});
         rouse(w_twi, n);
         chk(32'(n > 4 && n < 12), 1);
         if (m[i] == SM_STBY) chk(32'(n <= 9), 1);
         chk(32'(clk_en), 32'h7F);
      end
   endtask

   task automatic t_sources;
      int n;
      logic [2:0] rsv [3] = '{3'h4, 3'h5, 3'h7};
      foreach (rsv[i]) begin
         nap(rsv[i]);
         chk(32'(cpu_hold), 0);
      end
      crystal_clock_sel <= 0;
      nap(SM_STBY);
      chk(32'(cpu_hold), 0);
      crystal_clock_sel <= 1;
      nap(SM_PDOWN);
      rouse(w_io, n);
      chk(32'(cpu_hold), 1);
      rouse(w_hi, n);
      chk(32'(cpu_hold), 1);
      rouse(w_lo, n);
      chk(32'(cpu_hold), 0);
      timer2_irq_mask_reg <= 2'h0;
      nap(SM_PSAVE);
      rouse(w_ovf, n);
      chk(32'(cpu_hold), 1);
      timer2_irq_mask_reg <= 2'h1;
      rouse(w_ovf, n);
      chk(32'(cpu_hold), 0);
   endtask

   task automatic t_analog;
      int n;
      debug_enable_fuse <= 1;
      nap(SM_PDOWN);
      chk(32'(clk_en), 32'h02);
      chk({adc_on, bod_on, watchdog_on, comp_on, vref_on}, 5'h1D);
      chk({wake_buf_force, input_buf_en0}, 9'h100);
      rouse(w_twi, n);
      debug_enable_fuse <= 0;
      {adc_enable, comp_enable, brownout_level_fuses} <= {2'b00, 3'h7};
      repeat (3) @(posedge clk);
      chk({bod_on, vref_on}, 0);
      {adc_enable, comp_enable, brownout_level_fuses} <= {2'b11, 3'h6};
      repeat (3) @(posedge clk);
      chk(32'(adc_extended_next), 1);
   endtask

   task automatic t_scan;
      tap_shifting <= 1;
      repeat (3) @(posedge clk);
      chk({scan_port_on, tdo_oe}, 2'b11);
      bus(1, OFS_MCU_CTRL, 32'h80);
      repeat (2) @(posedge clk);
      chk({scan_port_on, tdo_oe}, 0);
      bus(1, OFS_MCU_CTRL, 0);
      scan_port_enable_fuse <= 0;
      repeat (3) @(posedge clk);
      chk(32'(scan_port_on), 0);
      {scan_port_enable_fuse, tap_shifting} <= 2'b10;
      repeat (3) @(posedge clk);
      chk({scan_port_on, tdo_oe}, 2'b10);
      tdo_data <= 1;
      repeat (2) @(posedge clk);
      chk(32'(tdo_out), 1);
   endtask

   task automatic print_verdict;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      #(20000 * 50);
      err_count++;
      print_verdict();
   end

   initial begin
      sys_rst = 1;
      {avs_read, avs_write, sleep_instr, debug_enable_fuse, comp_uses_ref} = '0;
      {tap_shifting, tdo_data, avs_address, avs_writedata, wake_in} = '0;
      {global_irq_en, timer2_async_select, crystal_clock_sel, wake_irq_en} = '1;
      {scan_port_enable_fuse, adc_enable, comp_enable, watchdog_enable} = '1;
      timer2_irq_mask_reg = 2'h3;
      brownout_level_fuses = 3'h6;
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      repeat (2) @(posedge clk);
      chk({avs_waitrequest, cpu_hold, 7'(clk_en)}, 9'h17F);
      t_regs();
      t_modes();
      t_sources();
      t_analog();
      t_scan();
      print_verdict();
   end
endmodule // test_sleep_ctrl
`default_nettype wire
